/* common/fm_synth_pkg.sv */
package fm_synth_pkg;
	// register byte offsets
	localparam logic [2:0] CTRL_OFFSET = 3'h0;
	localparam logic [2:0] MOD_OFFSET  = 3'h4;

	// control register fields
	localparam int IDIV_LSB   = 26;
	localparam int ODIV_LSB   = 24;
	localparam int LDIV_LSB   = 16;
	localparam int PSW_BIT    = 8;
	localparam int UNLOCK_BIT = 6;
	localparam int LEVT_BIT   = 5;
	localparam int LOCK_BIT   = 4;
	localparam int FMASK_BIT  = 3;
	localparam int FFLAG_BIT  = 2;

	// modulation register fields
	localparam int SKIP_BIT   = 31;
	localparam int SPRD_BIT   = 29;
	localparam int PER_LSB    = 16;
	localparam int MODEN_BIT  = 15;
	localparam int INC_LSB    = 0;

	// reset values
	localparam logic [3:0]  IDIV_RESET = 4'h0;
	localparam logic [1:0]  ODIV_RESET = 2'h0;
	localparam logic [6:0]  LDIV_RESET = 7'h20;
	localparam logic [12:0] PER_RESET  = 13'h0000;
	localparam logic [14:0] INC_RESET  = 15'h0000;

	// divider encodings
	localparam logic [3:0] IDIV_INHIBIT = 4'hF;
	localparam logic [6:0] LDIV_MIN     = 7'h20;
	localparam logic [6:0] LDIV_MAX     = 7'h60;

	// timing counts
	localparam logic [1:0] STROBE_CYCLES = 2'h2;
	localparam logic [5:0] STEP8_CYCLES  = 6'h08;
	localparam logic [5:0] STEP4_CYCLES  = 6'h10;
	localparam logic [5:0] STEP2_CYCLES  = 6'h20;

	// system clock divide codes
	localparam logic [4:0] SYS_DIV8 = 5'h08;
	localparam logic [4:0] SYS_DIV4 = 5'h04;
	localparam logic [4:0] SYS_DIV2 = 5'h02;
	localparam logic [4:0] SYS_DIV1 = 5'h01;

	typedef enum logic [2:0] {
		SW_IDLE,
		SW_DIV8,
		SW_DIV4,
		SW_DIV2,
		SW_FULL
	} switch_state_e;
endpackage

/* logic/progressive_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module progressive_divider
	import fm_synth_pkg::*;
(
	input  wire logic       clk_i,      // reference clock
	input  wire logic       rst_i,      // synchronous reset
	input  wire logic       enable_i,   // progressive switching on
	input  wire logic       locked_i,   // filtered lock level
	input  wire logic       tick_i,     // one loop output cycle
	output logic      [4:0] sys_div_o   // system clock divide ratio
);
	switch_state_e state;
	logic [5:0]    count;
	logic          locked_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			locked_q <= 1'b0;
		end else begin
			locked_q <= locked_i;
		end
	end

	// stepping starts on a lock rise; loss of lock waits for the next rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SW_IDLE;
			count <= 6'h00;
		end else if (!enable_i) begin
			state <= SW_IDLE;
			count <= 6'h00;
		end else if (!locked_i) begin
			state <= SW_IDLE;
			count <= 6'h00;
		end else begin
			case (state)
				SW_IDLE: begin
					if (locked_i && !locked_q) begin
						state <= SW_DIV8;
					end
					count <= 6'h00;
				end
				SW_DIV8: begin
					if (tick_i) begin
						if (count == STEP8_CYCLES - 6'h01) begin
							state <= SW_DIV4;
							count <= 6'h00;
						end else begin
							count <= count + 6'h01;
						end
					end
				end
				SW_DIV4: begin
					if (tick_i) begin
						if (count == STEP4_CYCLES - 6'h01) begin
							state <= SW_DIV2;
							count <= 6'h00;
						end else begin
							count <= count + 6'h01;
						end
					end
				end
				SW_DIV2: begin
					if (tick_i) begin
						if (count == STEP2_CYCLES - 6'h01) begin
							state <= SW_FULL;
							count <= 6'h00;
						end else begin
							count <= count + 6'h01;
						end
					end
				end
				SW_FULL: begin
					count <= 6'h00;
				end
				default: begin
					state <= SW_IDLE;
					count <= 6'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_div_o <= SYS_DIV1;
		end else begin
			case (state)
				SW_DIV8: sys_div_o <= SYS_DIV8;
				SW_DIV4: sys_div_o <= SYS_DIV4;
				SW_DIV2: sys_div_o <= SYS_DIV2;
				default: sys_div_o <= SYS_DIV1;
			endcase
		end
	end
endmodule
`default_nettype wire

/* logic/freq_mod_pll_control.sv */
`timescale 1ns/1ns
`default_nettype none
module freq_mod_pll_control
	import fm_synth_pkg::*;
(
	input  wire logic        clk_i,         // reference clock
	input  wire logic        rst_i,         // power-on reset, sync
	// classic wishbone slave
	input  wire logic        cyc_i,         // bus cycle
	input  wire logic        stb_i,         // strobe
	input  wire logic        we_i,          // write enable
	input  wire logic [2:0]  adr_i,         // byte address
	input  wire logic [3:0]  sel_i,         // byte lanes
	input  wire logic [31:0] dat_i,         // write data
	input  wire logic        supervisor_i,  // access privilege tag
	output logic      [31:0] dat_o,         // read data
	output logic             ack_o,         // normal end
	output logic             err_o,         // refused access
	// loop core side
	input  wire logic        lock_i,        // loop lock, asynchronous
	input  wire logic        powered_i,     // loop switched on, async
	input  wire logic        phi_tick_i,    // one loop output cycle
	output logic      [4:0]  input_ratio_o, // input divide ratio
	output logic             inhibit_o,     // input clock inhibit
	output logic      [4:0]  output_ratio_o,// output divide ratio
	output logic      [6:0]  loop_ratio_o,  // loop divide ratio
	output logic             loop_valid_o,  // loop code in range
	output logic      [4:0]  sys_div_o,     // system clock divide
	output logic             fail_o,        // external fail output
	output logic             strobe_o,      // modulation latch strobe
	output logic             mod_en_o,      // modulation active
	output logic             spread_o,      // spread type to core
	output logic      [12:0] period_o,      // modulation period
	output logic      [14:0] inc_o          // modulation increment
);
	////////////////////////////////////////////////////////////////
	logic [3:0]  input_divider_code;
	logic [1:0]  output_divider_code;
	logic [6:0]  loop_divider_code;
	logic        progressive_switch_enable;
	logic        unlock_once;
	logic        lock_event;
	logic        fail_mask;
	logic        fail_flag;
	logic        strobe_skip;
	logic        spread_type_select;
	logic [12:0] mod_period;
	logic        modulation_enable;
	logic [14:0] inc_step;

	logic [2:0]  lock_sync;
	logic [2:0]  pwr_sync;
	logic        locked;
	logic        powered;
	logic        locked_q;
	logic        mod_en_q;
	logic        lock_rise;
	logic        lock_fall;
	logic [1:0]  strobe_count;

	logic        req;
	logic        allowed;
	logic        mapped;
	logic        wr_ctrl;
	logic        wr_mod;
	logic [31:0] ctrl_word;
	logic [31:0] mod_word;
	logic [31:0] wmask;

	////////////////////////////////////////////////////////////////
	// pin synchronisers; a change counts once stages 2 and 3 agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_sync <= 3'h0;
			pwr_sync  <= 3'h0;
		end else begin
			lock_sync <= {lock_sync[1:0], lock_i};
			pwr_sync  <= {pwr_sync[1:0], powered_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			locked  <= 1'b0;
			powered <= 1'b0;
		end else begin
			if (lock_sync[1] == lock_sync[2]) begin
				locked <= lock_sync[2];
			end
			if (pwr_sync[1] == pwr_sync[2]) begin
				powered <= pwr_sync[2];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			locked_q <= 1'b0;
			mod_en_q <= 1'b0;
		end else begin
			locked_q <= locked;
			mod_en_q <= modulation_enable;
		end
	end

	// edges of the filtered lock level
	assign lock_rise = locked && !locked_q;
	assign lock_fall = !locked && locked_q;

	////////////////////////////////////////////////////////////////
	// wishbone decode
	assign req     = cyc_i && stb_i;
	assign allowed = supervisor_i;
	assign mapped  = (adr_i == CTRL_OFFSET) || (adr_i == MOD_OFFSET);
	assign wr_ctrl = req && ack_o && we_i && (adr_i == CTRL_OFFSET);
	assign wr_mod  = req && ack_o && we_i && (adr_i == MOD_OFFSET);

	always_comb begin
		wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	end

	// one-cycle answer; refused accesses end with err, nothing written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			ack_o <= req && !ack_o && !err_o && allowed && mapped;
			err_o <= req && !ack_o && !err_o && !(allowed && mapped);
		end
	end

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[IDIV_LSB +: 4] = input_divider_code;
		ctrl_word[ODIV_LSB +: 2] = output_divider_code;
		ctrl_word[LDIV_LSB +: 7] = loop_divider_code;
		ctrl_word[PSW_BIT]       = progressive_switch_enable;
		ctrl_word[UNLOCK_BIT]    = unlock_once;
		ctrl_word[LEVT_BIT]      = lock_event;
		ctrl_word[LOCK_BIT]      = locked;
		ctrl_word[FMASK_BIT]     = fail_mask;
		ctrl_word[FFLAG_BIT]     = fail_flag;
	end

	always_comb begin
		mod_word = 32'h0000_0000;
		mod_word[SKIP_BIT]       = strobe_skip;
		mod_word[SPRD_BIT]       = spread_type_select;
		mod_word[PER_LSB +: 13]  = mod_period;
		mod_word[MODEN_BIT]      = modulation_enable;
		mod_word[INC_LSB +: 15]  = inc_step;
	end

	// read data captured with the request, shown beside ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (req && !ack_o && allowed && !we_i) begin
			if (adr_i == CTRL_OFFSET) begin
				dat_o <= ctrl_word;
			end else if (adr_i == MOD_OFFSET) begin
				dat_o <= mod_word;
			end else begin
				dat_o <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// control register, plain fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_divider_code        <= IDIV_RESET;
			output_divider_code       <= ODIV_RESET;
			loop_divider_code         <= LDIV_RESET;
			progressive_switch_enable <= 1'b0;
			fail_mask                 <= 1'b0;
		end else if (wr_ctrl) begin
			if (sel_i[3]) begin
				input_divider_code  <= dat_i[IDIV_LSB +: 4];
				output_divider_code <= dat_i[ODIV_LSB +: 2];
			end
			if (sel_i[2]) begin
				loop_divider_code <= dat_i[LDIV_LSB +: 7];
			end
			if (sel_i[1]) begin
				progressive_switch_enable <= dat_i[PSW_BIT];
			end
			if (sel_i[0]) begin
				fail_mask <= dat_i[FMASK_BIT];
			end
		end
	end

	// sticky unlock, only reset clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unlock_once <= 1'b0;
		end else if (lock_fall) begin
			unlock_once <= 1'b1;
		end
	end

	// lock change event, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_event <= 1'b0;
		end else if (lock_rise || lock_fall) begin
			lock_event <= 1'b1;
		end else if (wr_ctrl && wmask[LEVT_BIT] && dat_i[LEVT_BIT]) begin
			lock_event <= 1'b0;
		end
	end

	// failure flag, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_flag <= 1'b0;
		end else if (lock_fall && powered) begin
			fail_flag <= 1'b1;
		end else if (wr_ctrl && wmask[FFLAG_BIT] && dat_i[FFLAG_BIT]) begin
			fail_flag <= 1'b0;
		end
	end

	assign fail_o = fail_flag && !fail_mask;

	////////////////////////////////////////////////////////////////
	// modulation register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_skip        <= 1'b0;
			spread_type_select <= 1'b0;
			mod_period         <= PER_RESET;
			modulation_enable  <= 1'b0;
			inc_step           <= INC_RESET;
		end else if (wr_mod) begin
			if (sel_i[3]) begin
				strobe_skip        <= dat_i[SKIP_BIT];
				spread_type_select <= dat_i[SPRD_BIT];
				mod_period[12:8]   <= dat_i[PER_LSB + 8 +: 5];
			end
			if (sel_i[2]) begin
				mod_period[7:0] <= dat_i[PER_LSB +: 8];
			end
			if (sel_i[1]) begin
				modulation_enable <= dat_i[MODEN_BIT];
				inc_step[14:8]    <= dat_i[INC_LSB + 8 +: 7];
			end
			if (sel_i[0]) begin
				inc_step[7:0] <= dat_i[INC_LSB +: 8];
			end
		end
	end

	// latch strobe, held for a fixed number of reference cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_count <= 2'h0;
		end else if ((modulation_enable && !mod_en_q && locked) ||
				(lock_rise && modulation_enable)) begin
			strobe_count <= STROBE_CYCLES;
		end else if (strobe_count != 2'h0) begin
			strobe_count <= strobe_count - 2'h1;
		end
	end

	assign strobe_o = (strobe_count != 2'h0);

	// settings seen by the core; triangle shape is fixed in the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spread_o <= 1'b0;
			period_o <= PER_RESET;
			inc_o    <= INC_RESET;
		end else if (strobe_skip || strobe_o) begin
			spread_o <= spread_type_select;
			period_o <= mod_period;
			inc_o    <= inc_step;
		end
	end

	// modulation counts as active only while locked
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mod_en_o <= 1'b0;
		end else begin
			mod_en_o <= modulation_enable && locked;
		end
	end

	////////////////////////////////////////////////////////////////
	// divider ratios
	// out-of-range loop codes are flagged only, never corrected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_ratio_o  <= 5'h01;
			inhibit_o      <= 1'b0;
			output_ratio_o <= 5'h02;
			loop_ratio_o   <= LDIV_RESET;
			loop_valid_o   <= 1'b1;
		end else begin
			input_ratio_o  <= {1'b0, input_divider_code} + 5'h01;
			inhibit_o      <= (input_divider_code == IDIV_INHIBIT);
			output_ratio_o <= 5'h02 << output_divider_code;
			loop_ratio_o   <= loop_divider_code;
			loop_valid_o   <= (loop_divider_code >= LDIV_MIN) &&
				(loop_divider_code <= LDIV_MAX);
		end
	end

	progressive_divider u_progressive (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.enable_i  (progressive_switch_enable),
		.locked_i  (locked),
		.tick_i    (phi_tick_i),
		.sys_div_o (sys_div_o)
	);
endmodule
`default_nettype wire

/* sim/loop_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module loop_core_model (
	input  wire logic clk_i,      // reference clock
	input  wire logic lock_req_i, // loop may settle
	input  wire logic pwr_req_i,  // loop switched on
	output logic      lock_o,     // lock level
	output logic      powered_o,  // power level
	output logic      phi_tick_o  // one loop output cycle
);
	// lock only holds while powered; output runs only when powered
	always_ff @(posedge clk_i) begin
		powered_o  <= pwr_req_i;
		lock_o     <= lock_req_i & pwr_req_i;
		phi_tick_o <= pwr_req_i;
	end
endmodule
`default_nettype wire

/* sim/fm_ctrl_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module fm_ctrl_props (
	input  wire logic       clk_i,          // clock
	input  wire logic       rst_i,          // reset
	input  wire logic       cyc_i,          // bus cycle
	input  wire logic       stb_i,          // strobe
	input  wire logic       supervisor_i,   // privilege
	input  wire logic       ack_o,          // normal end
	input  wire logic       err_o,          // refused
	input  wire logic [4:0] input_ratio_o,  // input ratio
	input  wire logic       inhibit_o,      // inhibit
	input  wire logic [4:0] output_ratio_o, // output ratio
	input  wire logic [6:0] loop_ratio_o,   // loop ratio
	input  wire logic       loop_valid_o,   // loop in range
	input  wire logic [4:0] sys_div_o,      // system divide
	input  wire logic       strobe_o        // latch strobe
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	assign req = cyc_i && stb_i && !ack_o && !err_o;
	property p_answer; req |=> (ack_o ^ err_o); endproperty
	a_answer: assert property (p_answer) else $error("no single answer");
	property p_user; req && !supervisor_i |=> err_o && !ack_o; endproperty
	a_user: assert property (p_user) else $error("user access taken");
	property p_pulse; (ack_o || err_o) |=> !(ack_o || err_o); endproperty
	a_pulse: assert property (p_pulse) else $error("answer too long");
	property p_inhibit; inhibit_o == (input_ratio_o == 5'h10); endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");
	property p_out; output_ratio_o inside {5'h02, 5'h04, 5'h08, 5'h10}; endproperty
	a_out: assert property (p_out) else $error("bad output ratio");
	property p_loop; loop_valid_o == (loop_ratio_o >= 7'h20 && loop_ratio_o <= 7'h60);
	endproperty
	a_loop: assert property (p_loop) else $error("loop valid wrong");
	property p_strobe; $rose(strobe_o) |=> strobe_o ##1 !strobe_o; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe not two cycles");
	property p_step;
		!$stable(sys_div_o) |-> sys_div_o inside {5'h01, 5'h08}
			|| sys_div_o == ($past(sys_div_o) >> 1);
	endproperty
	a_step: assert property (p_step) else $error("bad divide step");
endmodule
bind freq_mod_pll_control fm_ctrl_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i,
	.supervisor_i, .ack_o, .err_o, .input_ratio_o, .inhibit_o, .output_ratio_o,
	.loop_ratio_o, .loop_valid_o, .sys_div_o, .strobe_o);
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb import fm_synth_pkg::*;;
	localparam logic [31:0] LK = 32'h1 << LOCK_BIT;
	localparam logic [31:0] EV = 32'h1 << LEVT_BIT;
	localparam logic [31:0] UL = 32'h1 << UNLOCK_BIT;
	localparam logic [31:0] FM = 32'h1 << FMASK_BIT;
	localparam logic [31:0] FF = 32'h1 << FFLAG_BIT;
	localparam logic [31:0] ME = 32'h1 << MODEN_BIT;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic        we_i = 1'b0, sup_i = 1'b1, lock_req = 1'b0, pwr_req = 1'b1;
	logic [2:0]  adr_i = 3'h0;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, rq, cw, mw, seed = 32'h0000_51F0;
	logic        ack_o, err_o, re, inhibit_o, loop_valid_o, fail_o;
	logic        strobe_o, mod_en_o, spread_o, lock, powered, tick;
	logic [4:0]  input_ratio_o, output_ratio_o, sys_div_o;
	logic [6:0]  loop_ratio_o;
	logic [12:0] period_o;
	logic [14:0] inc_o;
	int          miscompares = 0, n_checks = 0, n;
	always #5 clk_i = ~clk_i;
	freq_mod_pll_control uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .supervisor_i(sup_i), .dat_o, .ack_o, .err_o, .lock_i(lock),
		.powered_i(powered), .phi_tick_i(tick), .input_ratio_o, .inhibit_o,
		.output_ratio_o, .loop_ratio_o, .loop_valid_o, .sys_div_o, .fail_o,
		.strobe_o, .mod_en_o, .spread_o, .period_o, .inc_o);
	loop_core_model core (.clk_i, .lock_req_i(lock_req), .pwr_req_i(pwr_req),
		.lock_o(lock), .powered_o(powered), .phi_tick_o(tick));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] ctrl(logic [3:0] i, logic [1:0] o, logic [6:0] l,
		logic p);
		return (32'(i) << IDIV_LSB) | (32'(o) << ODIV_LSB) | (32'(l) << LDIV_LSB)
			| (32'(p) << PSW_BIT);
	endfunction
	function automatic logic [31:0] modw(logic k, logic s, logic [12:0] p, logic [14:0] c);
		return (32'(k) << SKIP_BIT) | (32'(s) << SPRD_BIT) | (32'(p) << PER_LSB) | 32'(c);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [2:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (!ack_o && !err_o && k < 40);
		chk(k < 40, 1);
		rq = dat_o;
		re = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rq, e);
	endtask
	task automatic strobe_len();
		int k;
		k = 0;
		while (strobe_o !== 1'b1 && k < 12) begin
			@(posedge clk_i);
			k++;
		end
		k = 0;
		while (strobe_o === 1'b1 && k < 9) begin
			@(posedge clk_i);
			k++;
		end
		chk(k, 2);
	endtask
	task automatic stage(input logic [4:0] d, input int len);
		int k;
		k = 0;
		while (sys_div_o === d && k < 99) begin
			@(posedge clk_i);
			k++;
		end
		chk(k, len);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	initial begin
		logic [3:0]  ic;
		logic [6:0]  lc;
		logic [12:0] per;
		logic [14:0] inc;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(CTRL_OFFSET, ctrl(IDIV_RESET, ODIV_RESET, LDIV_RESET, 0));
		chk(sys_div_o, SYS_DIV1);
		sup_i <= 1'b0;
		wb(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
		chk(re, 1);
		sup_i <= 1'b1;
		wb(1'b1, 3'h2, 32'h0);
		chk(re, 1);
		rd_chk(CTRL_OFFSET, ctrl(IDIV_RESET, ODIV_RESET, LDIV_RESET, 0));
		for (int i = 0; i < 16; i++) begin
			ic = 4'(i);
			lc = (i == 0) ? LDIV_MIN : (i == 1) ? LDIV_MAX : 7'(32 + xs() % 65);
			cw = ctrl(ic, ic[1:0], lc, 1'b0);
			wb(1'b1, CTRL_OFFSET, cw);
			rd_chk(CTRL_OFFSET, cw);
			chk(input_ratio_o, 5'(ic) + 5'h1);
			chk(inhibit_o, ic == IDIV_INHIBIT);
			chk(output_ratio_o, 5'h2 << ic[1:0]);
			chk(loop_ratio_o, lc);
			chk(loop_valid_o, 1);
		end
		cw = ctrl(4'h1, 2'h1, 7'h28, 1'b1);
		wb(1'b1, CTRL_OFFSET, cw);
		lock_req <= 1'b1;
		n = 0;
		while (sys_div_o !== SYS_DIV8 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		stage(SYS_DIV8, 8);
		stage(SYS_DIV4, 16);
		stage(SYS_DIV2, 32);
		chk(sys_div_o, SYS_DIV1);
		rd_chk(CTRL_OFFSET, cw | LK | EV);
		wb(1'b1, CTRL_OFFSET, cw | EV);
		rd_chk(CTRL_OFFSET, cw | LK);
		lock_req <= 1'b0;
		repeat (8) @(posedge clk_i);
		rd_chk(CTRL_OFFSET, cw | EV | UL | FF);
		chk(fail_o, 1);
		wb(1'b1, CTRL_OFFSET, cw | FM);
		chk(fail_o, 0);
		wb(1'b1, CTRL_OFFSET, cw | FF);
		rd_chk(CTRL_OFFSET, cw | EV | UL);
		lock_req <= 1'b1;
		repeat (8) @(posedge clk_i);
		rd_chk(CTRL_OFFSET, cw | LK | EV | UL);
		per = 13'(xs() % 127 + 1);
		inc = 15'(xs() % 255 + 1);
		mw = modw(1'b0, 1'b1, per, inc);
		wb(1'b1, MOD_OFFSET, mw);
		repeat (4) @(posedge clk_i);
		chk(period_o, PER_RESET);
		wb(1'b1, MOD_OFFSET, mw | ME);
		strobe_len();
		repeat (2) @(posedge clk_i);
		chk(period_o, per);
		chk(inc_o, inc);
		chk(spread_o, 1);
		chk(mod_en_o, 1);
		rd_chk(MOD_OFFSET, mw | ME);
		lock_req <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(mod_en_o, 0);
		lock_req <= 1'b1;
		strobe_len();
		pwr_req <= 1'b0;
		repeat (8) @(posedge clk_i);
		per = per ^ 13'h007F;
		inc = inc ^ 15'h00FF;
		wb(1'b1, MOD_OFFSET, modw(1'b1, 1'b0, per, inc));
		repeat (2) @(posedge clk_i);
		chk(period_o, per);
		chk(inc_o, inc);
		chk(spread_o, 0);
		summarize();
	end
endmodule
`default_nettype wire
